// >>> afs_arc_stage.sv
// arc flash stage logic with apb registers
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Notes on behaviour
// - each stage picks light from none, S1, S2, S1/S2, or with binary input
// - stage starts whenever its selected light is seen
// - stage trips only on selected light plus overcurrent above pickup
// - phase stage compares largest phase current with pu pickup
// - earth stage compares residual current with pu pickup
// - any light counter counts light on S1, S2 or binary input
// - each stage counts starts on its own selected light
// - each stage counts its trips
// - light, start and trip counters clear to zero by software
// - one shared force flag, cleared after five minutes set
// - start and trip status writable only while force is set
// - settings writable only after password unlock
// - delayed light from own source choice, 0.01 s to 0.15 s
// - delayed light is an output matrix source
// - binary output is the or of its matrix sources
// - eight latest faults kept: date, ms time, value, elapsed percent
// - phase records also hold fault type and pre fault current
// ----------------------------------------------------------------
module afs_arc_stage
	import afs_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC,
	parameter int FORCE_TIMEOUT_MS = FORCE_MS,
	parameter logic [31:0] UNLOCK_KEY = KEY_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// light pins
	input wire logic light_sensor_one,
	input wire logic light_sensor_two,
	input wire logic peer_light_input,
	// measurements, currents in pu with 8 fraction bits
	input wire logic [15:0] largest_phase_current,
	input wire logic [15:0] residual_current,
	input wire logic [7:0] fault_type,
	input wire logic [31:0] date_stamp,
	input wire logic [31:0] time_of_day_ms,
	// outputs
	output logic peer_light_output,
	output logic phase_start,
	output logic phase_trip,
	output logic earth_start,
	output logic earth_trip,
	output logic delayed_light
);
	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic pick(input logic [2:0] s,
		input logic [2:0] v, input logic bi_only);
		pick = (s == SEL_BI_ONLY && !bi_only) ? 1'b0 : |(s & v);
	endfunction
	function automatic logic [7:0] clamp(input logic [7:0] d);
		clamp = d < DLY_MIN_MS ? DLY_MIN_MS :
			(d > DLY_MAX_MS ? DLY_MAX_MS : d);
	endfunction
	function automatic logic [15:0] bump(input logic [15:0] c,
		input logic ev, input logic clr);
		// an event in the clearing cycle still counts
		bump = clr ? {15'h0000, ev} : c + {15'h0000, ev};
	endfunction
	// ------------------------------------------------------------
	// pin synchronisers: change taken once stages two and three agree
	// ------------------------------------------------------------
	logic [2:0] s1_r, s2_r, s3_r, pin_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
			pin_r <= 3'h0;
		end else begin
			s1_r <= {peer_light_input, light_sensor_two,
				light_sensor_one};
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= (s2_r & s3_r) | (~(s2_r ^ s3_r) & s2_r) |
				((s2_r ^ s3_r) & pin_r);
		end
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic force_r, unlock_r;
	logic [31:0] phcfg_r, eacfg_r;
	logic [2:0] dsel_r;
	logic [7:0] dly_r;
	logic [MTX_W-1:0] mtx_r;
	logic [3:0] frc_r;
	logic [2:0] rsel_r;
	logic [CNT_W-1:0] lcnt_r, phs_r, pht_r, eas_r, eat_r;
	wire wr = psel && penable && pwrite;
	wire w_ctrl = wr && paddr == A_CTRL;
	wire w_key = wr && paddr == A_KEY;
	wire w_set = wr && unlock_r;
	wire w_stat = wr && paddr == A_STAT;
	wire w_clr = wr && paddr == A_LCNT;
	wire [4:0] clr = w_clr ? pwdata[4:0] : 5'h00;
	// ------------------------------------------------------------
	// stage logic
	// ------------------------------------------------------------
	wire ph_l = pick(phcfg_r[2:0], pin_r, 1'b0);
	wire ea_l = pick(eacfg_r[2:0], pin_r, 1'b0);
	wire dl_l = pick(dsel_r, pin_r, 1'b1);
	wire any_l = |pin_r;
	wire ph_oc = largest_phase_current > phcfg_r[31:PU_LSB];
	wire ea_oc = residual_current > eacfg_r[31:PU_LSB];
	wire [3:0] live = {ea_l && ea_oc, ea_l, ph_l && ph_oc, ph_l};
	logic [3:0] st_r, live_q;
	logic any_q, dly_out_r, bo_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= 4'h0;
			live_q <= 4'h0;
			any_q <= 1'b0;
		end else begin
			st_r <= force_r ? frc_r : live;
			live_q <= live;
			any_q <= any_l;
		end
	end
	assign {earth_trip, earth_start, phase_trip, phase_start} = st_r;
	wire [3:0] rise = live & ~live_q;
	// ------------------------------------------------------------
	// millisecond tick, force timeout, delayed light
	// ------------------------------------------------------------
	logic [31:0] ms_cnt_r, frc_ms_r;
	logic [7:0] dms_r;
	wire tick = ms_cnt_r == 32'(MS_CYCLES - 1);
	wire frc_end = frc_ms_r == 32'(FORCE_TIMEOUT_MS);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_r <= 32'h00000000;
			frc_ms_r <= 32'h00000000;
			force_r <= 1'b0;
			dms_r <= 8'h00;
		end else begin
			ms_cnt_r <= tick ? 32'h00000000 : ms_cnt_r + 32'h1;
			if (w_ctrl) begin
				force_r <= pwdata[0];
				frc_ms_r <= 32'h00000000;
			end else if (frc_end) begin
				force_r <= 1'b0;
				frc_ms_r <= 32'h00000000;
			end else if (force_r && tick) begin
				frc_ms_r <= frc_ms_r + 32'h1;
			end
			// whole ms steps: up to one ms early on first tick
			if (!dl_l)
				dms_r <= 8'h00;
			// compare by size so a shortened delay cannot wrap the count
			else if (tick && dms_r < dly_r)
				dms_r <= dms_r + 8'h01;
		end
	end
	wire dly_hit = dl_l && dms_r >= dly_r;
	// ------------------------------------------------------------
	// settings, force values, counters
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_r <= 1'b0;
			phcfg_r <= {PU_RST, 16'h0000};
			eacfg_r <= {PU_RST, 16'h0000};
			dsel_r <= 3'h0;
			dly_r <= DLY_RST_MS;
			mtx_r <= '0;
			frc_r <= 4'h0;
			rsel_r <= 3'h0;
		end else begin
			if (w_key)
				unlock_r <= pwdata == UNLOCK_KEY;
			if (w_set && paddr == A_PHCFG)
				phcfg_r <= {pwdata[31:PU_LSB], 13'h0000,
					pwdata[2:0]};
			if (w_set && paddr == A_EACFG)
				eacfg_r <= {pwdata[31:PU_LSB], 13'h0000,
					pwdata[2:0]};
			if (w_set && paddr == A_DLYCFG) begin
				dsel_r <= pwdata[2:0];
				dly_r <= clamp(pwdata[DLY_LSB+7:DLY_LSB]);
			end
			if (w_set && paddr == A_MATRIX)
				mtx_r <= pwdata[MTX_W-1:0];
			if (w_stat && force_r)
				frc_r <= pwdata[3:0];
			// drop old forced values so the next force starts clean
			if (force_r && (w_ctrl ? !pwdata[0] : frc_end))
				frc_r <= 4'h0;
			if (wr && paddr == A_RSEL)
				rsel_r <= pwdata[2:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcnt_r <= '0;
			phs_r <= '0;
			pht_r <= '0;
			eas_r <= '0;
			eat_r <= '0;
		end else begin
			lcnt_r <= bump(lcnt_r, any_l && !any_q, clr[0]);
			phs_r <= bump(phs_r, rise[0], clr[1]);
			pht_r <= bump(pht_r, rise[1], clr[2]);
			eas_r <= bump(eas_r, rise[2], clr[3]);
			eat_r <= bump(eat_r, rise[3], clr[4]);
		end
	end
	// ------------------------------------------------------------
	// output matrix
	// ------------------------------------------------------------
	wire [MTX_W-1:0] src = {dly_out_r, pin_r[2], st_r};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_out_r <= 1'b0;
			bo_r <= 1'b0;
		end else begin
			dly_out_r <= dly_hit;
			bo_r <= |(mtx_r & src);
		end
	end
	assign delayed_light = dly_out_r;
	assign peer_light_output = bo_r;
	// ------------------------------------------------------------
	// fault records
	// ------------------------------------------------------------
	logic [31:0] rdate_m [REC_N];
	logic [31:0] rtime_m [REC_N];
	logic [31:0] rflt_m [REC_N];
	logic [31:0] rph_m [REC_N];
	logic [2:0] wp_r;
	logic [3:0] rn_r;
	logic [15:0] load_r;
	// simultaneous trips keep only the phase record
	wire rec = rise[1] || rise[3];
	wire ph_rec = rise[1];
	wire [2:0] ridx = wp_r - 3'h1 - rsel_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r <= 3'h0;
			rn_r <= 4'h0;
			load_r <= 16'h0000;
		end else begin
			if (!ph_l)
				load_r <= largest_phase_current;
			if (rec) begin
				wp_r <= wp_r + 3'h1;
				if (rn_r != 4'(REC_N))
					rn_r <= rn_r + 4'h1;
			end
		end
	end
	always_ff @(posedge pclk) begin
		if (rec) begin
			rdate_m[wp_r] <= date_stamp;
			rtime_m[wp_r] <= time_of_day_ms;
			rflt_m[wp_r] <= {7'h00, !ph_rec, ELAPSED_DELAY_PERCENT_TRIP,
				ph_rec ? largest_phase_current :
				residual_current};
			rph_m[wp_r] <= ph_rec ? {8'h00, fault_type,
				load_r} : 32'h00000000;
		end
	end
	// ------------------------------------------------------------
	// apb read
	// ------------------------------------------------------------
	wire hit = paddr <= A_RPH && paddr[1:0] == 2'h0;
	wire recv = rsel_r < rn_r[2:0] || rn_r == 4'(REC_N);
	logic [31:0] rd;
	always_comb begin
		rd = 32'h00000000;
		case (paddr)
			A_CTRL: rd = {30'h0, unlock_r, force_r};
			A_PHCFG: rd = phcfg_r;
			A_EACFG: rd = eacfg_r;
			A_DLYCFG: rd = {16'h0, dly_r, 5'h00, dsel_r};
			A_MATRIX: rd = {26'h0, mtx_r};
			A_STAT: rd = {27'h0, dly_out_r, st_r};
			A_LCNT: rd = {16'h0, lcnt_r};
			A_PHCNT: rd = {pht_r, phs_r};
			A_EACNT: rd = {eat_r, eas_r};
			A_RSEL: rd = {20'h0, rn_r, 5'h00, rsel_r};
			A_RDATE: rd = recv ? rdate_m[ridx] : 32'h0;
			A_RTIME: rd = recv ? rtime_m[ridx] : 32'h0;
			A_RFLT: rd = recv ? rflt_m[ridx] : 32'h0;
			A_RPH: rd = recv ? rph_m[ridx] : 32'h0;
			default: rd = 32'h00000000;
		endcase
	end
	// data latched in the setup cycle, so the bus sees a flop output
	logic [31:0] prdata_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_r <= 32'h00000000;
		else if (psel && !penable)
			prdata_r <= rd;
	end
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_trip_light;
		@(posedge pclk) disable iff (!presetn)
		(!force_r && $past(!force_r) && phase_trip) |-> phase_start;
	endproperty
	a_trip_light: assert property (p_trip_light)
		else $error("trip without start");
	property p_start;
		@(posedge pclk) disable iff (!presetn)
		!force_r |=> (earth_start == $past(ea_l)) || force_r;
	endproperty
	a_start: assert property (p_start)
		else $error("start not following light");
	property p_force_to;
		@(posedge pclk) disable iff (!presetn)
		frc_end && !w_ctrl |=> !force_r;
	endproperty
	a_force_to: assert property (p_force_to)
		else $error("force not cleared at timeout");
	property p_frc_prot;
		@(posedge pclk) disable iff (!presetn)
		!force_r |=> $stable(frc_r);
	endproperty
	a_frc_prot: assert property (p_frc_prot)
		else $error("status written without force");
	property p_lock;
		@(posedge pclk) disable iff (!presetn)
		!unlock_r |=> $stable(phcfg_r) && $stable(mtx_r);
	endproperty
	a_lock: assert property (p_lock)
		else $error("setting changed while locked");
	property p_scnt;
		@(posedge pclk) disable iff (!presetn)
		rise[0] && !clr[1] |=> phs_r == $past(phs_r) + 16'h1;
	endproperty
	a_scnt: assert property (p_scnt)
		else $error("start count missed");
	property p_clr;
		@(posedge pclk) disable iff (!presetn)
		clr[2] && !rise[1] |=> pht_r == 16'h0000;
	endproperty
	a_clr: assert property (p_clr)
		else $error("trip count not cleared");
	property p_bo;
		@(posedge pclk) disable iff (!presetn)
		##1 peer_light_output == $past(|(mtx_r & src));
	endproperty
	a_bo: assert property (p_bo)
		else $error("binary output mismatch");
	property p_dly_drop;
		@(posedge pclk) disable iff (!presetn)
		!dl_l |=> !delayed_light;
	endproperty
	a_dly_drop: assert property (p_dly_drop)
		else $error("delayed light held without light");
	property p_rec;
		@(posedge pclk) disable iff (!presetn)
		rec |=> wp_r == $past(wp_r) + 3'h1;
	endproperty
	a_rec: assert property (p_rec)
		else $error("fault not recorded");
endmodule
`default_nettype wire

// >>> afs_peer.sv
// peer relay model on the far side of the arc light link
`timescale 1ns/1ps
`default_nettype none
module afs_peer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench command: peer sees light
	input wire logic flash,
	// link pins
	input wire logic peer_light_output,
	output logic peer_light_input,
	output logic [7:0] seen_r
);
	// ------------------------------------------------------------
	// link behaviour
	// ------------------------------------------------------------
	logic bo_r;
	// plain level, the peer adds no pulse shaping of its own
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peer_light_input <= 1'b0;
			bo_r <= 1'b0;
			seen_r <= 8'h00;
		end else begin
			peer_light_input <= flash;
			bo_r <= peer_light_output;
			if (peer_light_output && !bo_r)
				seen_r <= seen_r + 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> afs_pkg.sv
// constants for the arc flash stage logic
`default_nettype none
package afs_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_KEY = 8'h04;
	localparam logic [7:0] A_PHCFG = 8'h08;
	localparam logic [7:0] A_EACFG = 8'h0C;
	localparam logic [7:0] A_DLYCFG = 8'h10;
	localparam logic [7:0] A_MATRIX = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam logic [7:0] A_LCNT = 8'h1C;
	localparam logic [7:0] A_PHCNT = 8'h20;
	localparam logic [7:0] A_EACNT = 8'h24;
	localparam logic [7:0] A_RSEL = 8'h28;
	localparam logic [7:0] A_RDATE = 8'h2C;
	localparam logic [7:0] A_RTIME = 8'h30;
	localparam logic [7:0] A_RFLT = 8'h34;
	localparam logic [7:0] A_RPH = 8'h38;
	// ------------------------------------------------------------
	// fields and values
	// ------------------------------------------------------------
	localparam int SEL_W = 3;
	localparam int PU_LSB = 16;
	localparam int DLY_LSB = 8;
	localparam int MTX_W = 6;
	localparam int CNT_W = 16;
	localparam int REC_N = 8;
	localparam logic [2:0] SEL_BI_ONLY = 3'h4;
	localparam logic [7:0] DLY_MIN_MS = 8'h0A;
	localparam logic [7:0] DLY_MAX_MS = 8'h96;
	localparam logic [7:0] DLY_RST_MS = 8'h0A;
	localparam logic [7:0] ELAPSED_DELAY_PERCENT_TRIP = 8'h64;
	localparam logic [15:0] PU_RST = 16'h0100;
	// arbitrary unlock value
	localparam logic [31:0] KEY_DEF = 32'h0000A5C3;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam int TICK_MS = 1;
	localparam int MS_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int FORCE_MIN = 5;
	localparam int FORCE_MS = FORCE_MIN * 60 * 1000;
endpackage
`default_nettype wire

// >>> afs_tb.sv
// self-checking bench for the arc flash stage logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import afs_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic s1 = 1'b0;
	logic s2 = 1'b0;
	logic flash = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [7:0] lf = 8'h43;
	logic [7:0] seen;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [15:0] iph = 16'h0000;
	logic [15:0] ires = 16'h0000;
	logic pready, pslverr, bo, bi, err;
	logic ph_s, ph_t, ea_s, ea_t, dl;
	int failures = 0;
	int checked = 0;
	logic [31:0] exq[$];

	initial begin
		forever #5 pclk = ~pclk;
	end

	afs_arc_stage #(.MS_CYCLES(10), .FORCE_TIMEOUT_MS(5)) afs_arc_stage_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .light_sensor_one(s1),
		.light_sensor_two(s2), .peer_light_input(bi),
		.largest_phase_current(iph), .residual_current(ires),
		.fault_type(8'h5A), .date_stamp(32'h11223344),
		.time_of_day_ms(32'h0000ABCD), .peer_light_output(bo),
		.phase_start(ph_s), .phase_trip(ph_t), .earth_start(ea_s),
		.earth_trip(ea_t), .delayed_light(dl));

	afs_peer afs_peer_inst (.pclk(pclk), .presetn(presetn), .flash(flash),
		.peer_light_output(bo), .peer_light_input(bi), .seen_r(seen));

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic cmp(input logic [31:0] e, input logic [31:0] a);
		checked++;
		if (a !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t exp=%h act=%h", $time, e, a);
		end
	endtask

	task automatic end_of_test;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		forever begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// pin filter plus stage flop settle well inside 8 cycles
	task automatic pins(input logic a, input logic b, input logic c);
		@(posedge pclk);
		s1 <= a;
		s2 <= b;
		flash <= c;
		cyc(8);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			if (exq.size() > 0)
				cmp(exq.pop_front(), prdata);
	end

	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		end_of_test;
	end

	initial begin
		logic [2:0] src;
		logic st;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_CTRL, 32'h0);
		rd(A_PHCFG, {PU_RST, 16'h0000});
		wr(A_PHCFG, 32'h00050007);
		rd(A_PHCFG, {PU_RST, 16'h0000});
		apb(1'b0, 8'h3C, 32'h0);
		cmp(32'h1, {31'h0, err});
		wr(A_KEY, KEY_DEF);
		rd(A_CTRL, 32'h2);
		for (int i = 0; i < 16; i++) begin
			src = i[2:0];
			wr(A_PHCFG, {PU_RST, 13'h0, src});
			wr(A_EACFG, {PU_RST, 13'h0, src});
			lf = lfsr(lf);
			pins(lf[0], lf[1], lf[2]);
			st = (src != SEL_BI_ONLY) && ((src & lf[2:0]) != 3'h0);
			rd(A_STAT, {29'h0, st, 1'b0, st});
			cmp({29'h0, st, 1'b0, st}, {28'h0, ea_t, ea_s, ph_t, ph_s});
		end
		pins(1'b0, 1'b0, 1'b0);
		wr(A_PHCFG, {PU_RST, 16'h0001});
		wr(A_EACFG, {PU_RST, 16'h0001});
		iph <= 16'h0040;
		ires <= 16'h0100;
		pins(1'b1, 1'b0, 1'b0);
		rd(A_STAT, 32'h05);
		iph <= 16'h0101;
		cyc(8);
		rd(A_STAT, 32'h07);
		ires <= 16'h0101;
		cyc(8);
		rd(A_STAT, 32'h0F);
		cmp(32'hF, {28'h0, ea_t, ea_s, ph_t, ph_s});
		rd(A_RSEL, 32'h200);
		rd(A_RFLT, 32'h01640101);
		rd(A_RPH, 32'h0);
		rd(A_RDATE, 32'h11223344);
		wr(A_RSEL, 32'h1);
		rd(A_RFLT, 32'h00640101);
		rd(A_RPH, 32'h005A0040);
		rd(A_RTIME, 32'h0000ABCD);
		pins(1'b0, 1'b0, 1'b0);
		ires <= 16'h0000;
		iph <= 16'h0200;
		wr(A_LCNT, 32'h1F);
		rd(A_PHCNT, 32'h0);
		for (int i = 0; i < 10; i++) begin
			pins(1'b1, 1'b0, 1'b0);
			pins(1'b0, 1'b0, 1'b0);
		end
		rd(A_LCNT, 32'hA);
		rd(A_PHCNT, 32'h000A000A);
		rd(A_EACNT, 32'h0000000A);
		wr(A_RSEL, 32'h0);
		rd(A_RSEL, 32'h800);
		wr(A_LCNT, 32'h1F);
		rd(A_LCNT, 32'h0);
		wr(A_STAT, 32'h0F);
		rd(A_STAT, 32'h0);
		wr(A_CTRL, 32'h1);
		wr(A_STAT, 32'h0F);
		rd(A_STAT, 32'h0F);
		rd(A_CTRL, 32'h3);
		cyc(60);
		rd(A_CTRL, 32'h2);
		rd(A_STAT, 32'h0);
		wr(A_CTRL, 32'h1);
		rd(A_STAT, 32'h0);
		wr(A_CTRL, 32'h0);
		rd(A_CTRL, 32'h2);
		wr(A_DLYCFG, 32'h0504);
		rd(A_DLYCFG, 32'h0A04);
		wr(A_DLYCFG, 32'hFF04);
		rd(A_DLYCFG, 32'h9604);
		wr(A_DLYCFG, 32'h0A04);
		wr(A_MATRIX, 32'h20);
		pins(1'b0, 1'b0, 1'b1);
		cyc(72);
		rd(A_STAT, 32'h0);
		cyc(40);
		rd(A_STAT, 32'h10);
		cmp(32'h1, {31'h0, bo});
		cmp(32'h1, {31'h0, dl});
		pins(1'b0, 1'b0, 1'b0);
		rd(A_STAT, 32'h0);
		cmp(32'h0, {31'h0, dl});
		cmp(32'h1, {24'h0, seen});
		wr(A_MATRIX, 32'h10);
		pins(1'b0, 1'b0, 1'b1);
		cmp(32'h2, {24'h0, seen});
		wr(A_KEY, 32'h0);
		rd(A_CTRL, 32'h0);
		wr(A_MATRIX, 32'h0);
		rd(A_MATRIX, 32'h10);
		end_of_test;
	end
endmodule
`default_nettype wire
